/* core/otpc_core.sv */
// command decoder for otp crc check, crc readback, otp programming and option/user_identifier writes
`default_nettype none

module otpc_core
  import otpc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // byte stream from the serial front end, same clock
  input  wire logic        byte_strobe_in,
  input  wire logic        dc_sel_in,
  input  wire logic        rw_sel_in,
  input  wire logic [7:0]  wdata_in,
  // display update control state
  input  wire logic        clock_gate_flag_in,
  // status and read data
  output logic             busy_out,
  output logic [7:0]       rdata_out,
  output logic             rdata_valid_out,
  output logic [15:0]      crc_result_out,
  // decoded display option and user_identifier
  output logic [35:0]      display_mode_sel_out,
  output logic             alternating_frame_mode1_out,
  output logic             alternating_frame_mode2_out,
  output logic [31:0]      module_id_out,
  output logic [79:0]      display_option_out,
  output logic [79:0]      user_identifier_out
);

  //==================================================================
  // crc step over one byte
  function automatic logic [15:0] otpc_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int b = 0; b < 8; b++) begin
      if (c[15]) begin
        c = {c[14:0], 1'b0} ^ OTPC_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  //==================================================================
  // storage
  otpc_state_type  state_q;
  otpc_state_type  state_d;
  otpc_target_type target_q;
  otpc_target_type target_d;
  logic [4:0]      idx_q;
  logic [4:0]      idx_d;
  logic [11:0]     wait_q;
  logic [11:0]     wait_d;
  logic [15:0]     crc_acc_q;
  logic [15:0]     crc_acc_d;
  logic [15:0]     crc_result_q;
  logic [15:0]     crc_result_d;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic            rvalid_q;
  logic            rvalid_d;
  logic [7:0]      opt_q [OTPC_PARAM_BYTES];
  logic [7:0]      uid_q [OTPC_PARAM_BYTES];
  logic [7:0]      otp_mem_q [OTPC_OTP_BYTES];

  //==================================================================
  // strobe decode
  wire logic       idle_w;
  wire logic       cmd_stb_w;
  wire logic       wr_stb_w;
  wire logic       rd_stb_w;
  wire logic       idx_in_param_w;
  wire logic       opt_wr_w;
  wire logic       uid_wr_w;
  wire logic       prog_tick_w;
  wire logic       prog_last_w;
  wire logic       crc_last_w;
  wire logic [7:0] prog_src_w;
  wire logic [4:0] uid_idx_w;
  wire logic [7:0] crc_byte_w;
  wire logic [15:0] crc_next_w;

  assign idle_w         = (state_q == OTPC_IDLE);
  // commands and data are dropped while busy; the host is expected to wait
  assign cmd_stb_w      = byte_strobe_in && !dc_sel_in && idle_w;
  assign wr_stb_w       = byte_strobe_in && dc_sel_in && !rw_sel_in && idle_w;
  assign rd_stb_w       = byte_strobe_in && dc_sel_in && rw_sel_in && idle_w;
  assign idx_in_param_w = (idx_q <= OTPC_LAST_PARAM);
  assign opt_wr_w       = wr_stb_w && (target_q == OTPC_TGT_OPT) && idx_in_param_w;
  assign uid_wr_w       = wr_stb_w && (target_q == OTPC_TGT_UID) && idx_in_param_w;
  assign prog_tick_w    = (state_q == OTPC_PROG_RUN) && (wait_q == OTPC_PROG_CYCLES - 12'h001);
  assign prog_last_w    = prog_tick_w && (idx_q == OTPC_LAST_OTP);
  assign crc_last_w     = (state_q == OTPC_CRC_RUN) && (idx_q == OTPC_LAST_OTP);
  assign uid_idx_w      = idx_q - 5'(OTPC_PARAM_BYTES);
  // option bytes fill the first half of the otp image, user_identifier the second
  assign prog_src_w     = idx_in_param_w ? opt_q[idx_q[3:0]] : uid_q[uid_idx_w[3:0]];
  assign crc_byte_w     = otp_mem_q[idx_q];
  assign crc_next_w     = otpc_crc_byte(crc_acc_q, crc_byte_w);

  //==================================================================
  // sequencer
  always_comb begin
    state_d      = state_q;
    target_d     = target_q;
    idx_d        = idx_q;
    wait_d       = wait_q;
    crc_acc_d    = crc_acc_q;
    crc_result_d = crc_result_q;
    rdata_d      = rdata_q;
    rvalid_d     = 1'b0;
    unique case (state_q)
      OTPC_IDLE: begin
        if (cmd_stb_w) begin
          idx_d    = 5'h00;
          wait_d   = 12'h000;
          target_d = OTPC_TGT_NONE;
          unique case (wdata_in)
            OTPC_CMD_CRC_CALC: begin
              state_d   = OTPC_CRC_RUN;
              crc_acc_d = OTPC_CRC_INIT;
            end
            OTPC_CMD_CRC_READ: begin
              target_d = OTPC_TGT_CRC;
            end
            OTPC_CMD_OTP_PROG: begin
              // without the clock gate the charge pump is off, so burning is refused
              if (clock_gate_flag_in) begin
                state_d = OTPC_PROG_RUN;
              end
            end
            OTPC_CMD_DISP_OPT: begin
              target_d = OTPC_TGT_OPT;
            end
            OTPC_CMD_USER_IDENTIFIER: begin
              target_d = OTPC_TGT_UID;
            end
            default: begin
              target_d = OTPC_TGT_NONE;
            end
          endcase
        end else if (wr_stb_w) begin
          if (idx_in_param_w) begin
            idx_d = idx_q + 5'h01;
          end
        end else if (rd_stb_w) begin
          rvalid_d = 1'b1;
          if (target_q == OTPC_TGT_CRC && idx_q == 5'h00) begin
            rdata_d = crc_result_q[15:8];
          end else if (target_q == OTPC_TGT_CRC && idx_q == 5'h01) begin
            rdata_d = crc_result_q[7:0];
          end else begin
            rdata_d = OTPC_BYTE_RESET;
          end
          if (idx_in_param_w) begin
            idx_d = idx_q + 5'h01;
          end
        end
      end
      OTPC_CRC_RUN: begin
        // one otp byte per cycle; busy stays high across all of them
        crc_acc_d = crc_next_w;
        idx_d     = idx_q + 5'h01;
        if (crc_last_w) begin
          crc_result_d = crc_next_w;
          state_d      = OTPC_IDLE;
          idx_d        = 5'h00;
        end
      end
      OTPC_PROG_RUN: begin
        if (prog_tick_w) begin
          wait_d = 12'h000;
          idx_d  = idx_q + 5'h01;
          if (prog_last_w) begin
            state_d = OTPC_IDLE;
            idx_d   = 5'h00;
          end
        end else begin
          wait_d = wait_q + 12'h001;
        end
      end
      default: begin
        state_d = OTPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q      <= OTPC_IDLE;
      target_q     <= OTPC_TGT_NONE;
      idx_q        <= 5'h00;
      wait_q       <= 12'h000;
      crc_acc_q    <= OTPC_CRC_RESET;
      crc_result_q <= OTPC_CRC_RESET;
      rdata_q      <= OTPC_BYTE_RESET;
      rvalid_q     <= 1'b0;
    end else begin
      state_q      <= state_d;
      target_q     <= target_d;
      idx_q        <= idx_d;
      wait_q       <= wait_d;
      crc_acc_q    <= crc_acc_d;
      crc_result_q <= crc_result_d;
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
    end
  end

  //==================================================================
  // option and user_identifier registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < OTPC_PARAM_BYTES; i++) begin
        opt_q[i] <= OTPC_BYTE_RESET;
        uid_q[i] <= OTPC_BYTE_RESET;
      end
    end else begin
      if (opt_wr_w) begin
        opt_q[idx_q[3:0]] <= wdata_in;
      end
      if (uid_wr_w) begin
        uid_q[idx_q[3:0]] <= wdata_in;
      end
    end
  end

  //==================================================================
  // otp image; reset stands in for a blank part in simulation
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < OTPC_OTP_BYTES; i++) begin
        otp_mem_q[i] <= OTPC_OTP_BLANK;
      end
    end else if (prog_tick_w) begin
      otp_mem_q[idx_q] <= prog_src_w;
    end
  end

  //==================================================================
  // field outputs
  genvar g;
  generate
    for (g = 0; g < OTPC_PARAM_BYTES; g++) begin : g_flat
      assign display_option_out[79 - 8*g -: 8]  = opt_q[g];
      assign user_identifier_out[79 - 8*g -: 8] = uid_q[g];
    end
    for (g = 0; g < 4; g++) begin : g_mode
      // byte B covers indices 7:0, up to byte E for 31:24
      assign display_mode_sel_out[8*g +: 8] = opt_q[OTPC_MODE_FIRST + g];
    end
    for (g = 0; g < OTPC_MODULE_BYTES; g++) begin : g_mod
      assign module_id_out[31 - 8*g -: 8] = opt_q[OTPC_MODULE_FIRST + g];
    end
  endgenerate

  assign display_mode_sel_out[35:32]  = opt_q[OTPC_MODE_FIRST + 4][3:0];
  assign alternating_frame_mode2_out  = opt_q[OTPC_MODE_FIRST + 4][OTPC_ALT_MODE2_BIT];
  assign alternating_frame_mode1_out  = opt_q[OTPC_MODE_FIRST + 4][OTPC_ALT_MODE1_BIT];

  //==================================================================
  // status
  assign busy_out        = !idle_w;
  assign rdata_out       = rdata_q;
  assign rdata_valid_out = rvalid_q;
  assign crc_result_out  = crc_result_q;

endmodule

`default_nettype wire

/* core/otpc_pkg.sv */
// constants, command codes and layouts for the otp option/crc command block
//==================================================================
// Summary of operation
// - command 0x34 runs a crc over the otp contents; busy high until done
// - command 0x35 returns the crc as two read bytes, high byte first
// - command 0x36 programs otp from option and user_identifier registers when clock_gate_flag_in is high; busy high throughout
// - command 0x37 takes ten parameter bytes A to J; byte A is zero (the code stores byte A as written and does not check it)
// - bytes B to E and F[3:0] pick display mode per waveform index; 1 is mode 2
// - F[6] enables alternating frames for mode 2, F[7] for mode 1
// - bytes G to J hold the module identifier and waveform version
// - all ten option bytes A to J can be written into otp
// - command 0x38 takes ten parameter bytes stored as the user identifier
`default_nettype none

package otpc_pkg;

  //==================================================================
  // command codes
  localparam logic [7:0] OTPC_CMD_CRC_CALC  = 8'h34;
  localparam logic [7:0] OTPC_CMD_CRC_READ  = 8'h35;
  localparam logic [7:0] OTPC_CMD_OTP_PROG  = 8'h36;
  localparam logic [7:0] OTPC_CMD_DISP_OPT  = 8'h37;
  localparam logic [7:0] OTPC_CMD_USER_IDENTIFIER   = 8'h38;

  //==================================================================
  // register sizes and layout
  localparam int         OTPC_PARAM_BYTES   = 10;
  localparam int         OTPC_OTP_BYTES     = 20;
  localparam logic [4:0] OTPC_LAST_PARAM    = 5'h09;
  localparam logic [4:0] OTPC_LAST_OTP      = 5'h13;
  localparam int         OTPC_MODE_FIRST    = 1;
  localparam int         OTPC_MODE_BITS     = 36;
  localparam int         OTPC_ALT_MODE2_BIT = 6;
  localparam int         OTPC_ALT_MODE1_BIT = 7;
  localparam int         OTPC_MODULE_FIRST  = 6;
  localparam int         OTPC_MODULE_BYTES  = 4;

  //==================================================================
  // reset values
  localparam logic [7:0]  OTPC_BYTE_RESET   = 8'h00;
  localparam logic [7:0]  OTPC_OTP_BLANK    = 8'h00;
  localparam logic [15:0] OTPC_CRC_RESET    = 16'h0000;

  //==================================================================
  // crc-16, polynomial x^16+x^12+x^5+1, preset all ones
  localparam logic [15:0] OTPC_CRC_POLY     = 16'h1021;
  localparam logic [15:0] OTPC_CRC_INIT     = 16'hFFFF;

  //==================================================================
  // timing: time to burn one otp byte
  localparam int          OTPC_CLK_MHZ       = 100;
  localparam int          OTPC_PROG_BYTE_NS  = 1000;
  localparam int          OTPC_PROG_CYCLES_I = (OTPC_PROG_BYTE_NS * OTPC_CLK_MHZ + 999) / 1000;
  localparam logic [11:0] OTPC_PROG_CYCLES   = 12'(OTPC_PROG_CYCLES_I);

  //==================================================================
  // types
  typedef enum logic [1:0] {
    OTPC_IDLE,
    OTPC_CRC_RUN,
    OTPC_PROG_RUN
  } otpc_state_type;

  typedef enum logic [1:0] {
    OTPC_TGT_NONE,
    OTPC_TGT_CRC,
    OTPC_TGT_OPT,
    OTPC_TGT_UID
  } otpc_target_type;

endpackage

`default_nettype wire

/* verif/otpc_monitor.sv */
// checker on the ports of the otp option/crc command block
`default_nettype none
module otpc_monitor
  import otpc_pkg::*;
(
  // clock, reset, byte port and clock gate flag
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        byte_strobe_in,
  input wire logic        dc_sel_in,
  input wire logic        rw_sel_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        clock_gate_flag_in,
  // status and registers
  input wire logic        busy_out,
  input wire logic [7:0]  rdata_out,
  input wire logic        rdata_valid_out,
  input wire logic [15:0] crc_result_out,
  input wire logic [35:0] display_mode_sel_out,
  input wire logic        alternating_frame_mode1_out,
  input wire logic        alternating_frame_mode2_out,
  input wire logic [31:0] module_id_out,
  input wire logic [79:0] display_option_out,
  input wire logic [79:0] user_identifier_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take    = byte_strobe_in & ~busy_out;
  wire cmd     = take & ~dc_sel_in;
  wire rd_take = take & dc_sel_in & rw_sel_in;
  // length of the current busy span, so a long operation can be checked end to end
  logic [11:0] busy_cnt_q;
  always_ff @(posedge clk_in) begin
    if (srst_in || !busy_out) begin
      busy_cnt_q <= 12'h000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 12'h001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  //==================================================================
  // timing of busy and read data
  a_crc_busy_span: assert property (
    cmd && wdata_in == OTPC_CMD_CRC_CALC |=> busy_out [*8] ##12 busy_out ##1 !busy_out)
    else $error("crc busy span wrong");
  a_prog_busy_held: assert property (
    cmd && wdata_in == OTPC_CMD_OTP_PROG && clock_gate_flag_in |=> busy_out [*8] ##300 busy_out)
    else $error("program busy dropped early");
  a_prog_gate_refuse: assert property (
    cmd && wdata_in == OTPC_CMD_OTP_PROG && !clock_gate_flag_in |=> !busy_out)
    else $error("program ran with gate flag low");
  a_read_valid_due: assert property (take && dc_sel_in && rw_sel_in |=> rdata_valid_out)
    else $error("read byte not answered");
  a_valid_has_cause: assert property (rdata_valid_out |-> $past(rd_take))
    else $error("read data without read byte");
  a_busy_span_len: assert property ($fell(busy_out) |->
    busy_cnt_q == 12'(OTPC_OTP_BYTES) || busy_cnt_q == 12'(OTPC_OTP_BYTES * OTPC_PROG_CYCLES_I))
    else $error("busy span has wrong length");
  a_busy_ignores_bytes: assert property (
    busy_out && byte_strobe_in |=> $stable(display_option_out) && !rdata_valid_out)
    else $error("byte taken while busy");
  //==================================================================
  // option decoding
  a_mode_sel_map: assert property (display_mode_sel_out == {display_option_out[35:32],
    display_option_out[47:40], display_option_out[55:48], display_option_out[63:56], display_option_out[71:64]})
    else $error("display mode map wrong");
  a_alt_frame_bits: assert property (
    {alternating_frame_mode1_out, alternating_frame_mode2_out} == display_option_out[39:38])
    else $error("alternating frame bits wrong");
  a_module_id_bytes: assert property (module_id_out == display_option_out[31:0])
    else $error("module id bytes wrong");
endmodule
`default_nettype wire

/* verif/otpc_host_model.sv */
// host model driving command and parameter bytes
`default_nettype none
module otpc_host_model (
  input  wire logic       clk_in,
  output var  logic       strobe_out,
  output var  logic       dc_out,
  output var  logic       rw_out,
  output var  logic [7:0] data_out,
  output var  logic       gate_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    strobe_out = 1'b0;
    dc_out = 1'b0;
    rw_out = 1'b0;
    data_out = 8'h00;
    gate_out = 1'b0;
  end
  // one byte per call; the data line is inverted once the strobe drops
  task automatic send(input logic dc, input logic rw, input logic [7:0] d);
    @(posedge clk_in);
    strobe_out <= 1'b1;
    dc_out <= dc;
    rw_out <= rw;
    data_out <= d;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    data_out <= ~d;
  endtask
  task automatic gate(input logic v);
    @(posedge clk_in);
    gate_out <= v;
  endtask
endmodule
`default_nettype wire

/* verif/otpc_tb_top.sv */
// self-checking bench for the otp option/crc command block
`default_nettype none
module otpc_tb_top
  import otpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, srst_in, byte_strobe_in, dc_sel_in, rw_sel_in, clock_gate_flag_in;
  logic busy_out, rdata_valid_out, alternating_frame_mode1_out, alternating_frame_mode2_out;
  logic [7:0]  wdata_in, rdata_out;
  logic [15:0] crc_result_out;
  logic [35:0] display_mode_sel_out;
  logic [31:0] module_id_out;
  logic [79:0] display_option_out, user_identifier_out, opt_m, uid_m;
  int          num_errors, n_compared, n;
  otpc_core dut_u (.clk_in, .srst_in, .byte_strobe_in, .dc_sel_in, .rw_sel_in, .wdata_in,
    .clock_gate_flag_in, .busy_out, .rdata_out, .rdata_valid_out, .crc_result_out, .display_mode_sel_out,
    .alternating_frame_mode1_out, .alternating_frame_mode2_out, .module_id_out, .display_option_out,
    .user_identifier_out);
  otpc_host_model host_u (.clk_in, .strobe_out(byte_strobe_in), .dc_out(dc_sel_in), .rw_out(rw_sel_in),
    .data_out(wdata_in), .gate_out(clock_gate_flag_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(string nm, logic [79:0] seen, logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bounded wait for busy low; returns the edges spent busy
  task automatic wait_idle(output int c);
    c = 0;
    while (busy_out !== 1'b0) begin
      @(posedge clk_in);
      #1;
      c++;
      if (c > 3000) begin
        num_errors++;
        give_verdict();
      end
    end
  endtask
  function automatic logic [15:0] crc_m(logic [159:0] img);
    logic [15:0] c;
    c = OTPC_CRC_INIT;
    for (int i = 19; i >= 0; i--) begin
      c = c ^ {img[i*8 +: 8], 8'h00};
      for (int k = 0; k < 8; k++)
        c = c[15] ? ({c[14:0], 1'b0} ^ OTPC_CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task automatic rd(logic [7:0] exp);
    host_u.send(1'b1, 1'b1, 8'h00);
    #1;
    chk("rdata_valid", rdata_valid_out, 1'b1);
    chk("rdata", rdata_out, exp);
  endtask
  task automatic wr10(logic [7:0] cmd, output logic [79:0] v);
    host_u.send(1'b0, 1'b0, cmd);
    for (int i = 9; i >= 0; i--) begin
      v[i*8 +: 8] = 8'($urandom);
      if (cmd == OTPC_CMD_DISP_OPT && i == 9) v[79:72] = 8'h00;
      host_u.send(1'b1, 1'b0, v[i*8 +: 8]);
    end
    @(posedge clk_in);
    #1;
  endtask
  task automatic crc_run(logic [159:0] img);
    logic [15:0] e;
    e = crc_m(img);
    host_u.send(1'b0, 1'b0, OTPC_CMD_CRC_CALC);
    #1;
    wait_idle(n);
    chk("crc_cycles", n, 20);
    chk("crc", crc_result_out, e);
    host_u.send(1'b0, 1'b0, OTPC_CMD_CRC_READ);
    rd(e[15:8]);
    rd(e[7:0]);
    rd(8'h00);
    $display("test crc done");
  endtask
  initial begin
    num_errors = 0;
    n_compared = 0;
    srst_in = 1'b1;
    void'($urandom(32'h3E8B3F4E));
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    chk("busy", busy_out, 1'b0);
    chk("option", display_option_out, 80'h0);
    wr10(OTPC_CMD_DISP_OPT, opt_m);
    chk("option", display_option_out, opt_m);
    chk("mode", display_mode_sel_out, {opt_m[35:32], opt_m[47:40], opt_m[55:48], opt_m[63:56], opt_m[71:64]});
    chk("alt", {alternating_frame_mode1_out, alternating_frame_mode2_out}, opt_m[39:38]);
    chk("module_id", module_id_out, opt_m[31:0]);
    wr10(OTPC_CMD_USER_IDENTIFIER, uid_m);
    chk("user_identifier", user_identifier_out, uid_m);
    $display("test option write done");
    // an eleventh byte and bytes after a foreign code must leave both registers alone
    host_u.send(1'b1, 1'b0, 8'hA5);
    host_u.send(1'b0, 1'b0, 8'h3A);
    host_u.send(1'b1, 1'b0, 8'h5A);
    rd(8'h00);
    chk("option_kept", display_option_out, opt_m);
    chk("user_identifier_kept", user_identifier_out, uid_m);
    $display("test refused write done");
    crc_run(160'h0);
    host_u.send(1'b0, 1'b0, OTPC_CMD_OTP_PROG);
    #1;
    chk("busy_refused", busy_out, 1'b0);
    host_u.gate(1'b1);
    host_u.send(1'b0, 1'b0, OTPC_CMD_OTP_PROG);
    #1;
    // a read byte sent while busy must be dropped
    host_u.send(1'b1, 1'b1, 8'h00);
    wait_idle(n);
    chk("prog_cycles", n, 1998);
    $display("test program done");
    crc_run({opt_m, uid_m});
    give_verdict();
  end
endmodule
bind otpc_core otpc_monitor mon_u (.clk_in, .srst_in, .byte_strobe_in, .dc_sel_in, .rw_sel_in, .wdata_in,
  .clock_gate_flag_in, .busy_out, .rdata_out, .rdata_valid_out, .crc_result_out, .display_mode_sel_out,
  .alternating_frame_mode1_out, .alternating_frame_mode2_out, .module_id_out, .display_option_out,
  .user_identifier_out);
`default_nettype wire
